// >>> core/urt_core.sv
// serial transmitter/receiver with two-deep receive queue, AHB-Lite registers
// ************************************************************
// ************************************************************
`default_nettype none
module urt_core (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic serial_in_owned,
  input wire logic tx_done_irq_ack,
  output logic tx_empty_irq,
  output logic tx_done_irq,
  output logic rx_ready_irq
);
  import urt_pkg::*;

  // ************************************************************
  // tick generator
  // ************************************************************
  urt_tick_if tk ();
  urt_baud u_baud (
    .hclk(hclk),
    .hresetn(hresetn),
    .tk(tk)
  );

  logic [7:0] csb;
  logic [7:0] csc;
  logic [BAUD_W-1:0] baud;
  assign tk.divisor = baud;

  function automatic logic maj3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  logic [2:0] size_code;
  logic [3:0] nbits;
  logic [8:0] size_mask;
  assign size_code = {csb[CSB_SZ2], csc[CSC_SZ1], csc[CSC_SZ0]};
  assign nbits = (size_code == SZ_NINE) ? NINE_BITS : SZ_BASE + {2'b00, size_code[1:0]};
  assign size_mask = 9'h1ff >> (NINE_BITS - nbits);

  // ************************************************************
  // bus decode
  // ************************************************************
  logic addr_ok;
  logic rd_take;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic data_wr;
  logic data_rd;
  assign addr_ok = hsel & htrans[1] & hready;
  assign rd_take = addr_ok & ~hwrite;
  assign data_rd = rd_take & (haddr[7:0] == OFS_DATA) & (haddr[31:8] == 24'h000000);
  assign data_wr = wr_pend & (wr_addr == OFS_DATA);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'hff;
    end else begin
      wr_pend <= addr_ok & hwrite & (haddr[31:8] == 24'h000000);
      wr_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      csb <= CSB_RESET;
      csc <= CSC_RESET;
      baud <= BAUD_RESET;
    end else if (wr_pend) begin
      if (wr_addr == OFS_CSB) begin
        csb <= hwdata[7:0] & ~(8'h01 << CSB_RXB8);
      end
      if (wr_addr == OFS_CSC) begin
        csc <= hwdata[7:0];
      end
      if (wr_addr == OFS_BAUD) begin
        baud <= hwdata[BAUD_W-1:0];
      end
    end
  end

  // ************************************************************
  // transmit buffer and shifter
  // ************************************************************
  logic tx_buf_full;
  logic [8:0] tx_buf;
  logic tx_on;
  logic tx_done;
  urt_tx_e tx_st;
  logic [3:0] tx_ph;
  logic [3:0] tx_idx;
  logic [8:0] tx_sh;
  logic [3:0] tx_nb;
  logic tx_pen;
  logic tx_par;
  logic tx_stop2;
  logic tx_stop_idx;
  logic tx_bit_end;
  logic tx_load;
  logic tx_frame_end;
  assign tx_bit_end = tk.tick & (tx_ph == PH_LAST);
  assign tx_load = tx_buf_full & tx_on & (tx_st == TX_IDLE);
  assign tx_frame_end = tx_bit_end & (tx_st == TX_STOP) & (tx_stop_idx | ~tx_stop2);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_buf_full <= 1'b0;
      tx_buf <= '0;
    end else if (data_wr) begin
      tx_buf_full <= 1'b1;
      tx_buf <= {csb[CSB_TXB8], hwdata[7:0]};
    end else if (tx_load) begin
      tx_buf_full <= 1'b0;
    end
  end

  // disable holds off until nothing is pending, then the pin is let go
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_on <= 1'b0;
    end else if (csb[CSB_TXEN]) begin
      tx_on <= 1'b1;
    end else if (!tx_buf_full && tx_st == TX_IDLE) begin
      tx_on <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st <= TX_IDLE;
      tx_ph <= '0;
      tx_idx <= '0;
      tx_sh <= '0;
      tx_nb <= '0;
      tx_pen <= 1'b0;
      tx_par <= 1'b0;
      tx_stop2 <= 1'b0;
      tx_stop_idx <= 1'b0;
      serial_out_pin <= 1'b1;
    end else begin
      if (tk.tick) begin
        tx_ph <= tx_ph + 1'b1;
      end
      case (tx_st)
        TX_IDLE: begin
          serial_out_pin <= 1'b1;
          if (tx_load) begin
            tx_st <= TX_START;
            tx_ph <= '0;
            tx_sh <= tx_buf & size_mask;
            tx_nb <= nbits;
            tx_pen <= csc[CSC_PEN];
            tx_par <= (^(tx_buf & size_mask)) ^ csc[CSC_PODD];
            tx_stop2 <= csc[CSC_STOP2];
            serial_out_pin <= 1'b0;
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            tx_st <= TX_DATA;
            tx_idx <= '0;
            serial_out_pin <= tx_sh[0];
            tx_sh <= tx_sh >> 1;
          end
        end
        TX_DATA: begin
          if (tx_bit_end) begin
            tx_idx <= tx_idx + 1'b1;
            if (tx_idx + 1'b1 < tx_nb) begin
              serial_out_pin <= tx_sh[0];
              tx_sh <= tx_sh >> 1;
            end else if (tx_pen) begin
              tx_st <= TX_PAR;
              serial_out_pin <= tx_par;
            end else begin
              tx_st <= TX_STOP;
              tx_stop_idx <= 1'b0;
              serial_out_pin <= 1'b1;
            end
          end
        end
        TX_PAR: begin
          if (tx_bit_end) begin
            tx_st <= TX_STOP;
            tx_stop_idx <= 1'b0;
            serial_out_pin <= 1'b1;
          end
        end
        TX_STOP: begin
          if (tx_frame_end) begin
            tx_st <= TX_IDLE;
          end else if (tx_bit_end) begin
            tx_stop_idx <= 1'b1;
          end
        end
        default: begin
          tx_st <= TX_IDLE;
        end
      endcase
    end
  end

  // event wins over a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_done <= 1'b0;
    end else if (tx_frame_end && !tx_buf_full) begin
      tx_done <= 1'b1;
    end else if (tx_done_irq_ack) begin
      tx_done <= 1'b0;
    end else if (wr_pend && wr_addr == OFS_CSA && hwdata[CSA_TXC]) begin
      tx_done <= 1'b0;
    end
  end

  // ************************************************************
  // receiver
  // ************************************************************
  urt_rx_e rx_st;
  logic rx_en;
  logic rx_prev;
  logic [3:0] rx_ph;
  logic [2:0] rx_smp;
  logic [3:0] rx_idx;
  logic [8:0] rx_data;
  logic rx_perr;
  logic rx_bit_end;
  logic rx_bit;
  logic hold_valid;
  urt_rxent_s hold;
  logic [1:0] q_cnt;
  logic q_rd;
  logic q_wr;
  urt_rxent_s q_mem [0:1];
  logic q_push;
  logic q_pop;
  logic start_edge;
  assign rx_en = csb[CSB_RXEN];
  assign rx_bit_end = tk.tick & (rx_ph == PH_LAST);
  assign rx_bit = maj3(rx_smp);
  assign start_edge = rx_en & rx_prev & ~serial_in_pin & (rx_st == RX_IDLE);
  assign q_push = hold_valid & (q_cnt < RXQ_DEPTH);
  assign q_pop = data_rd & (q_cnt != 2'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_prev <= 1'b1;
    end else begin
      rx_prev <= serial_in_pin;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_smp <= '0;
    end else if (tk.tick && (rx_ph == PH_SMP_A || rx_ph == PH_SMP_B || rx_ph == PH_SMP_C)) begin
      rx_smp <= {rx_smp[1:0], serial_in_pin};
    end
  end

  // while the shifter still holds an unqueued frame a new start is refused
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st <= RX_IDLE;
      rx_ph <= '0;
      rx_idx <= '0;
      rx_data <= '0;
      rx_perr <= 1'b0;
      hold_valid <= 1'b0;
      hold <= '0;
    end else if (!rx_en) begin
      rx_st <= RX_IDLE;
      hold_valid <= 1'b0;
    end else begin
      if (tk.tick) begin
        rx_ph <= rx_ph + 1'b1;
      end
      if (q_push) begin
        hold_valid <= 1'b0;
      end
      case (rx_st)
        RX_IDLE: begin
          if (start_edge && hold_valid && !q_push && q_cnt == RXQ_DEPTH) begin
            hold.dor <= 1'b1;
          end else if (start_edge && (!hold_valid || q_push)) begin
            rx_st <= RX_START;
            rx_ph <= '0;
            rx_data <= '0;
            rx_idx <= '0;
          end
        end
        RX_START: begin
          if (rx_bit_end) begin
            rx_st <= rx_bit ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_bit_end) begin
            rx_data[rx_idx] <= rx_bit;
            rx_idx <= rx_idx + 1'b1;
            if (rx_idx + 1'b1 >= nbits) begin
              rx_st <= csc[CSC_PEN] ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_bit_end) begin
            rx_perr <= (^rx_data) ^ csc[CSC_PODD] ^ rx_bit;
            rx_st <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_bit_end) begin
            rx_st <= RX_IDLE;
            hold_valid <= 1'b1;
            hold.data <= rx_data;
            hold.fe <= ~rx_bit;
            hold.pe <= csc[CSC_PEN] & rx_perr;
            hold.dor <= 1'b0;
            rx_perr <= 1'b0;
          end
        end
        default: begin
          rx_st <= RX_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // receive queue, two entries
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_cnt <= '0;
      q_rd <= 1'b0;
      q_wr <= 1'b0;
    end else if (!rx_en) begin
      q_cnt <= '0;
      q_rd <= 1'b0;
      q_wr <= 1'b0;
    end else begin
      if (q_push) begin
        q_wr <= ~q_wr;
      end
      if (q_pop) begin
        q_rd <= ~q_rd;
      end
      q_cnt <= q_cnt + {1'b0, q_push} - {1'b0, q_pop};
    end
  end

  always_ff @(posedge hclk) begin
    if (q_push) begin
      q_mem[q_wr] <= hold;
    end
  end

  urt_rxent_s head;
  logic rx_ready;
  assign head = (q_cnt != 2'h0) ? q_mem[q_rd] : '0;
  assign rx_ready = (q_cnt != 2'h0);

  // ************************************************************
  // read data, sampled in the address phase
  // ************************************************************
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    case (haddr[7:0])
      OFS_DATA: next_rdata[8:0] = {1'b0, head.data[7:0]};
      OFS_CSA: begin
        next_rdata[CSA_RXC] = rx_ready;
        next_rdata[CSA_TXC] = tx_done;
        next_rdata[CSA_UDRE] = ~tx_buf_full;
        next_rdata[CSA_FE] = head.fe;
        next_rdata[CSA_DOR] = head.dor;
        next_rdata[CSA_PE] = head.pe;
      end
      OFS_CSB: begin
        next_rdata[7:0] = csb;
        next_rdata[CSB_RXB8] = head.data[8];
      end
      OFS_CSC: next_rdata[7:0] = csc;
      OFS_BAUD: next_rdata[BAUD_W-1:0] = baud;
      default: next_rdata = '0;
    endcase
    if (haddr[31:8] != 24'h000000) begin
      next_rdata = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_take) begin
      hrdata <= next_rdata;
    end
  end

  // ************************************************************
  // pin ownership and requests (global masking stays outside)
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_out_oe <= 1'b0;
      serial_in_owned <= 1'b0;
      tx_empty_irq <= 1'b0;
      tx_done_irq <= 1'b0;
      rx_ready_irq <= 1'b0;
    end else begin
      serial_out_oe <= tx_on;
      serial_in_owned <= rx_en;
      tx_empty_irq <= ~tx_buf_full & csb[CSB_UDRIE];
      tx_done_irq <= tx_done & csb[CSB_TXCIE];
      rx_ready_irq <= rx_ready & csb[CSB_RXCIE];
    end
  end
endmodule
`default_nettype wire

// >>> core/urt_pkg.sv
// constants, field layouts and types shared by the serial port core
`default_nettype none
package urt_pkg;
  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_CSA = 8'h04;
  localparam logic [7:0] OFS_CSB = 8'h08;
  localparam logic [7:0] OFS_CSC = 8'h0c;
  localparam logic [7:0] OFS_BAUD = 8'h10;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CSA_RXC = 7;
  localparam int CSA_TXC = 6;
  localparam int CSA_UDRE = 5;
  localparam int CSA_FE = 4;
  localparam int CSA_DOR = 3;
  localparam int CSA_PE = 2;
  localparam int CSB_RXCIE = 7;
  localparam int CSB_TXCIE = 6;
  localparam int CSB_UDRIE = 5;
  localparam int CSB_RXEN = 4;
  localparam int CSB_TXEN = 3;
  localparam int CSB_SZ2 = 2;
  localparam int CSB_RXB8 = 1;
  localparam int CSB_TXB8 = 0;
  localparam int CSC_PEN = 5;
  localparam int CSC_PODD = 4;
  localparam int CSC_STOP2 = 3;
  localparam int CSC_SZ1 = 2;
  localparam int CSC_SZ0 = 1;
  // ************************************************************
  // reset values, sizes, timing
  // ************************************************************
  localparam logic [7:0] CSB_RESET = 8'h00;
  localparam logic [7:0] CSC_RESET = 8'h06;
  localparam int BAUD_W = 12;
  localparam logic [BAUD_W-1:0] BAUD_RESET = 12'h03f;
  localparam logic [2:0] SZ_NINE = 3'h7;
  localparam logic [3:0] SZ_BASE = 4'h5;
  localparam logic [3:0] NINE_BITS = 4'h9;
  localparam logic [3:0] PH_SMP_A = 4'h7;
  localparam logic [3:0] PH_SMP_B = 4'h8;
  localparam logic [3:0] PH_SMP_C = 4'h9;
  localparam logic [3:0] PH_LAST = 4'hf;
  localparam logic [1:0] RXQ_DEPTH = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} urt_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} urt_rx_e;
  typedef struct packed {
    logic dor;
    logic pe;
    logic fe;
    logic [8:0] data;
  } urt_rxent_s;
endpackage
`default_nettype wire

// >>> core/urt_tick_if.sv
// carrier between the core and its oversampling tick generator
`default_nettype none
interface urt_tick_if;
  logic [urt_pkg::BAUD_W-1:0] divisor;
  logic tick;
  modport gen (input divisor, output tick);
  modport use_tick (output divisor, input tick);
endinterface
`default_nettype wire

// >>> core/urt_baud.sv
// oversampling tick generator: one tick every divisor+1 clocks
`default_nettype none
module urt_baud (
  input wire logic hclk,
  input wire logic hresetn,
  urt_tick_if.gen tk
);
  import urt_pkg::*;
  logic [BAUD_W-1:0] cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
      tk.tick <= 1'b0;
    end else if (cnt >= tk.divisor) begin
      cnt <= '0;
      tk.tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tk.tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> dv/urt_core_chk.sv
// assertion checker on the serial port core ports
`default_nettype none
module urt_core_chk
  import urt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe,
  input wire logic serial_in_owned,
  input wire logic tx_empty_irq,
  input wire logic rx_ready_irq
);
  // ********
  // data phase tracking
  // ********
  logic dp_on;
  logic dp_wr;
  logic [7:0] dp_adr;
  logic [2:0] since_pop;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_on <= 1'b0;
      dp_wr <= 1'b0;
      dp_adr <= 8'h00;
    end else if (hready) begin
      dp_on <= hsel && htrans[1] && haddr[31:8] == 24'h000000;
      dp_wr <= hwrite;
      dp_adr <= haddr[7:0];
    end
  end
  // a queue pop or a control write are the only causes for the rx request to drop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since_pop <= 3'h7;
    end else if (dp_on && (dp_adr == OFS_DATA && !dp_wr || dp_adr == OFS_CSB && dp_wr)) begin
      since_pop <= 3'h0;
    end else if (since_pop != 3'h7) begin
      since_pop <= since_pop + 3'h1;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_load;
    dp_on && dp_wr && dp_adr == OFS_DATA;
  endsequence
  sequence s_rx_off;
    dp_on && dp_wr && dp_adr == OFS_CSB && !hwdata[CSB_RXEN];
  endsequence
  sequence s_low_bit;
    (!serial_out_pin && serial_out_oe)[*8];
  endsequence
  property p_okay;
    hreadyout && hresp == HRESP_OKAY;
  endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
  property p_load;
    s_load |-> ##2 !tx_empty_irq;
  endproperty
  a_load: assert property (p_load) else $error("empty request after data write");
  property p_idle;
    !serial_out_oe |-> serial_out_pin;
  endproperty
  a_idle: assert property (p_idle) else $error("tx line low while released");
  property p_start;
    $fell(serial_out_pin) |-> s_low_bit;
  endproperty
  a_start: assert property (p_start) else $error("short low bit on tx line");
  property p_drop;
    $fell(rx_ready_irq) |-> since_pop <= 3'h4;
  endproperty
  a_drop: assert property (p_drop) else $error("rx request dropped with data left");
  property p_own;
    s_rx_off |-> ##[1:3] !serial_in_owned;
  endproperty
  a_own: assert property (p_own) else $error("rx pin still owned after disable");
  property p_flush;
    s_rx_off |-> ##[1:4] !rx_ready_irq;
  endproperty
  a_flush: assert property (p_flush) else $error("rx request kept after disable");
  property p_upper;
    dp_on && !dp_wr && dp_adr == OFS_DATA |-> hrdata[31:8] == 24'h000000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper data bits not zero");
endmodule
bind urt_core urt_core_chk u_urt_core_chk (.*);
`default_nettype wire

// >>> dv/urt_remote.sv
// remote serial station: frame sender and tx line monitor
`default_nettype none
module urt_remote (
  input wire logic hclk,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe,
  output logic serial_in_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // one bit is 16 clocks with a zero divisor
  localparam int BT = 16;
  int n_bits = 8;
  logic [15:0] f;
  logic [15:0] got_q[$];
  initial serial_in_pin = 1'b1;
  // start bit, then n bits lsb first ending with the stop bit
  task automatic send(input logic [15:0] bits, input int n);
    serial_in_pin <= 1'b0;
    repeat (BT) @(posedge hclk);
    for (int i = 0; i < n; i++) begin
      serial_in_pin <= bits[i];
      repeat (BT) @(posedge hclk);
    end
    serial_in_pin <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask
  always @(negedge serial_out_pin) begin
    if (serial_out_oe) begin
      repeat (BT / 2) @(posedge hclk);
      f = 16'h0;
      for (int i = 0; i <= n_bits; i++) begin
        repeat (BT) @(posedge hclk);
        f[i] = serial_out_pin;
      end
      got_q.push_back(f);
    end
  end
endmodule
`default_nettype wire

// >>> dv/urt_core_test.sv
// self-checking bench for the serial port core against a remote station
`default_nettype none
module urt_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  import urt_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic serial_in_pin, serial_out_pin, serial_out_oe, serial_in_owned;
  logic tx_done_irq_ack, tx_empty_irq, tx_done_irq, rx_ready_irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  int failures = 0;
  int num_checks = 0;
  urt_rxent_s rxq[$];
  urt_rxent_s held;
  logic held_v = 1'b0;
  logic pen = 1'b0;
  logic podd = 1'b0;
  logic [7:0] rst_a[5] = '{OFS_BAUD, OFS_CSB, OFS_CSC, OFS_CSA, 8'h14};
  logic [31:0] rst_v[5] = '{32'h3f, 32'h0, 32'h6, 32'h20, 32'h0};
  logic [2:0] sz[5] = '{3'h0, 3'h1, 3'h2, 3'h3, SZ_NINE};
  assign hready = hreadyout;
  urt_core u_urt_core (.*);
  urt_remote u_urt_remote (.*);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // ********
  // bus and compare tasks
  // ********
  task automatic wait_rdy();
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_pin(input string n, input logic e, input logic g);
    chk_reg(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic chk_frame(input logic [15:0] e, input logic [15:0] g);
    chk_reg("tx frame", {16'h0, e}, {16'h0, g});
  endtask
  // ********
  // receive model: two-entry queue plus the frame held in the shifter
  // ********
  task automatic rx_send(input logic [8:0] d, input int n, input logic bad, input logic stop);
    logic [15:0] b;
    urt_rxent_s e;
    e.data = d & ((9'h1 << n) - 9'h1);
    e.fe = ~stop;
    e.pe = pen & bad;
    e.dor = 1'b0;
    b = {7'h0, e.data};
    if (pen) b[n] = (^e.data) ^ podd ^ bad;
    b[n + pen] = stop;
    u_urt_remote.send(b, n + pen + 1);
    if (rxq.size() < 2) begin
      rxq.push_back(e);
    end else if (!held_v) begin
      held = e;
      held_v = 1'b1;
    end else begin
      held.dor = 1'b1;
    end
  endtask
  task automatic rx_pop(input logic nine);
    urt_rxent_s e;
    e = rxq.pop_front();
    rd(OFS_CSA);
    chk_reg("rx status", {24'h0, 3'b101, e.fe, e.dor, e.pe, 2'b00}, q);
    if (nine) begin
      rd(OFS_CSB);
      chk_reg("ninth bit", {24'h0, 6'h25, e.data[8], 1'b0}, q);
    end
    rd(OFS_DATA);
    chk_reg("rx data", {24'h0, e.data[7:0]}, q);
    if (held_v) begin
      rxq.push_back(held);
      held_v = 1'b0;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge hclk);
    failures++;
    $display("wrong value run time expected finish seen hang");
    report_and_stop();
  end
  initial begin
    logic [7:0] d[2];
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    tx_done_irq_ack = 1'b0;
    void'($urandom(32'he24639d4));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rst_a[i]) begin
      rd(rst_a[i]);
      chk_reg("reset value", rst_v[i], q);
    end
    wr(OFS_BAUD, 32'h0);
    $display("test reset values done");
    wr(OFS_CSB, 32'h68);
    u_urt_remote.n_bits = 9;
    for (int m = 0; m < 2; m++) begin
      wr(OFS_CSC, 32'h26 | (m << 4) | (m << 3));
      for (int k = 0; k < 2; k++) begin
        d[k] = 8'($urandom);
        wr(OFS_DATA, {24'h0, d[k]});
      end
      rd(OFS_CSA);
      chk_reg("tx status busy", 32'h0, q);
      chk_pin("empty irq", 1'b0, tx_empty_irq);
      while (u_urt_remote.got_q.size() < 2) @(posedge hclk);
      for (int k = 0; k < 2; k++) begin
        chk_frame({6'h0, 1'b1, (^d[k]) ^ m[0], d[k]}, u_urt_remote.got_q.pop_front());
      end
      while (tx_done_irq !== 1'b1) @(posedge hclk);
      rd(OFS_CSA);
      chk_reg("tx status done", 32'h60, q);
      chk_pin("empty irq", 1'b1, tx_empty_irq);
      if (m == 0) begin
        wr(OFS_CSA, 32'h40);
      end else begin
        tx_done_irq_ack <= 1'b1;
        @(posedge hclk);
        tx_done_irq_ack <= 1'b0;
      end
      rd(OFS_CSA);
      chk_reg("tx status cleared", 32'h20, q);
      chk_pin("done irq", 1'b0, tx_done_irq);
    end
    for (int k = 0; k < 2; k++) wr(OFS_DATA, 32'h55 + k);
    wr(OFS_CSB, 32'h60);
    chk_pin("tx pin owned", 1'b1, serial_out_oe);
    while (serial_out_oe !== 1'b0) @(posedge hclk);
    chk_reg("frames sent", 32'h2, 32'(u_urt_remote.got_q.size()));
    wr(OFS_CSA, 32'h40);
    $display("test transmit done");
    pen = 1'b1;
    wr(OFS_CSC, 32'h26);
    wr(OFS_CSB, 32'h90);
    rx_send(9'($urandom), 8, 1'b0, 1'b1);
    rx_send(9'($urandom), 8, 1'b1, 1'b1);
    rx_send(9'($urandom), 8, 1'b0, 1'b0);
    rx_send(9'h0ff, 8, 1'b0, 1'b1);
    chk_pin("rx irq", 1'b1, rx_ready_irq);
    while (rxq.size() > 0) rx_pop(1'b0);
    rx_send(9'($urandom), 8, 1'b0, 1'b1);
    rx_pop(1'b0);
    // request is registered, one edge behind the pop
    @(posedge hclk);
    chk_pin("rx irq", 1'b0, rx_ready_irq);
    $display("test receive errors done");
    pen = 1'b0;
    foreach (sz[i]) begin
      wr(OFS_CSC, {29'h0, sz[i][1:0], 1'b0});
      wr(OFS_CSB, {24'h0, 5'h12, sz[i][2], 2'b00});
      rx_send(9'($urandom), sz[i] == SZ_NINE ? 9 : sz[i] + 5, 1'b0, 1'b1);
      rx_pop(sz[i] == SZ_NINE);
    end
    $display("test sizes done");
    pen = 1'b1;
    podd = 1'b1;
    wr(OFS_CSC, 32'h3e);
    wr(OFS_CSB, 32'h90);
    rx_send(9'($urandom), 8, 1'b0, 1'b1);
    fork
      u_urt_remote.send(16'h2a5, 10);
      begin
        repeat (60) @(posedge hclk);
        wr(OFS_CSB, 32'h80);
      end
    join
    rxq.delete();
    held_v = 1'b0;
    chk_pin("rx pin owned", 1'b0, serial_in_owned);
    rd(OFS_CSA);
    chk_reg("flushed status", 32'h20, q);
    chk_pin("rx irq", 1'b0, rx_ready_irq);
    wr(OFS_CSB, 32'h90);
    rx_send(9'($urandom), 8, 1'b0, 1'b0);
    rx_pop(1'b0);
    $display("test receive disable done");
    report_and_stop();
  end
endmodule
`default_nettype wire
